// file: common/csf_pkg.sv
// Constants and carrier types for the status flag and register set block.
// Assumes a single processor clock and a synchronous active-high reset.
`default_nettype none
package csf_pkg;
  // ----------------------------------------------------------------
  // Flag word layout
  // ----------------------------------------------------------------
  localparam int unsigned CSF_BIT_CARRY = 0;
  localparam int unsigned CSF_BIT_PARITY = 2;
  localparam int unsigned CSF_BIT_HALF = 4;
  localparam int unsigned CSF_BIT_ZERO = 6;
  localparam int unsigned CSF_BIT_SIGN = 7;
  localparam int unsigned CSF_BIT_TRAP = 8;
  localparam int unsigned CSF_BIT_INTEN = 9;
  localparam int unsigned CSF_BIT_DIR = 10;
  localparam int unsigned CSF_BIT_OVFL = 11;
  localparam logic [15:0] CSF_RESULT_MASK = 16'h08D5;
  localparam logic [15:0] CSF_CTRL_MASK = 16'h0700;
  localparam logic [15:0] CSF_FLAGS_RESET = 16'h0000;
  localparam logic [15:0] CSF_REG_RESET = 16'h0000;
  // Count of the byte-splittable registers, slots 0 to 3
  localparam int unsigned CSF_NUM_BYTE_REGS = 4;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CSF_OP_ADD = 3'h0,
    CSF_OP_ADC = 3'h1,
    CSF_OP_SUB = 3'h2,
    CSF_OP_SBB = 3'h3,
    CSF_OP_AND = 3'h4,
    CSF_OP_OR = 3'h5,
    CSF_OP_XOR = 3'h6,
    CSF_OP_PASS = 3'h7
  } csf_op_e;

  // Register write request from the execution unit
  typedef struct packed {
    logic en;
    logic [2:0] idx;
    logic [1:0] lanes;
    logic [15:0] data;
  } csf_wr_s;

  // ALU request
  typedef struct packed {
    logic en;
    csf_op_e op;
    logic byte_mode;
    logic [15:0] a;
    logic [15:0] b;
  } csf_alu_s;
endpackage
`default_nettype wire

// file: core/csf_regfile.sv
// Eight-entry general register memory with registered read data.
// Assumes byte-lane writes come from the execution unit on core_clk.
`default_nettype none
module csf_regfile
  import csf_pkg::*;
#(
  parameter int unsigned DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Write port
  input wire csf_wr_s wr,
  // Read ports
  input wire logic [2:0] rd_a_idx,
  input wire logic [2:0] rd_b_idx,
  output logic [15:0] rd_a_q,
  output logic [15:0] rd_b_q,
  // Stored words, for the address operand paths
  output logic [DEPTH-1:0][15:0] mem_q
);
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [15:0] ra;
    logic [15:0] rb;
  } csf_rf_s;

  csf_rf_s st_q, st_d;
  logic [1:0] lanes_v;

  always_comb begin
    st_d = st_q;
    // only the low slots split into bytes; others take whole words
    lanes_v = (32'(wr.idx) < CSF_NUM_BYTE_REGS) ? wr.lanes : 2'h3;
    if (wr.en) begin
      if (lanes_v[0]) begin
        st_d.mem[wr.idx][7:0] = wr.data[7:0];
      end
      if (lanes_v[1]) begin
        st_d.mem[wr.idx][15:8] = wr.data[15:8];
      end
    end
    st_d.ra = st_d.mem[rd_a_idx];
    st_d.rb = st_d.mem[rd_b_idx];
  end

  // static storage, holds while clock stops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_a_q = st_q.ra;
  assign rd_b_q = st_q.rb;
  assign mem_q = st_q.mem;
endmodule // csf_regfile
`default_nettype wire

// file: core/csf_core.sv
// Flag word, segment registers, instruction pointer and general registers.
// Assumes the execution unit issues one request per cycle on core_clk.
`default_nettype none
module csf_core
  import csf_pkg::*;
#(
  parameter int unsigned NUM_GEN = 8,
  parameter int unsigned NUM_SEG = 4
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // ALU request
  input wire csf_alu_s alu,
  // General register access
  input wire csf_wr_s gen_wr,
  input wire logic [2:0] rd_a_idx,
  input wire logic [2:0] rd_b_idx,
  output logic [15:0] rd_a_q,
  output logic [15:0] rd_b_q,
  // Addressing: base and index select
  input wire logic [1:0] base_sel,
  input wire logic [1:0] index_sel,
  input wire logic [15:0] disp,
  output logic [15:0] eff_offset_q,
  // Segment registers
  input wire logic seg_wr_en,
  input wire logic [1:0] seg_idx,
  input wire logic [15:0] seg_data,
  output logic [NUM_SEG-1:0][15:0] seg_q,
  // Instruction pointer
  input wire logic instr_done,
  input wire logic [3:0] instr_len,
  input wire logic ip_load,
  input wire logic [15:0] ip_data,
  output logic [15:0] ip_q,
  // Flag word control
  input wire logic flags_load,
  input wire logic [15:0] flags_data,
  input wire logic maskable_req,
  input wire logic string_step,
  output logic [15:0] flags_q,
  output logic [15:0] alu_result_q,
  output logic take_maskable_q,
  output logic single_step_irq_q,
  output logic [15:0] string_delta_q
);
  typedef struct packed {
    logic [15:0] flags;
    logic [NUM_SEG-1:0][15:0] seg;
    logic [15:0] ip;
    logic [15:0] res;
    logic [15:0] eff;
    logic take_int;
    logic step_irq;
    logic [15:0] delta;
    logic trap_armed;
  } csf_core_s;

  csf_core_s st_q, st_d;
  logic [16:0] sum;
  logic [4:0] nib;
  logic [15:0] res;
  logic cin, sub_op, cout, hc, ovf, msb, zero;
  logic [15:0] base_v, index_v;
  logic [15:0] bx_v, bp_v, si_v, di_v;
  logic [NUM_GEN-1:0][15:0] gen_regs;

  csf_regfile #(.DEPTH(NUM_GEN)) u_regfile (
    .core_clk(core_clk),
    .reset(reset),
    .wr(gen_wr),
    .rd_a_idx(rd_a_idx),
    .rd_b_idx(rd_b_idx),
    .rd_a_q(rd_a_q),
    .rd_b_q(rd_b_q),
    .mem_q(gen_regs)
  );

  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  always_comb begin
    sub_op = (alu.op == CSF_OP_SUB) || (alu.op == CSF_OP_SBB);
    cin = ((alu.op == CSF_OP_ADC) || (alu.op == CSF_OP_SBB))
          && st_q.flags[CSF_BIT_CARRY];
    if (sub_op) begin
      sum = {1'b0, alu.a} - {1'b0, alu.b} - {16'h0000, cin};
      nib = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, cin};
    end else begin
      sum = {1'b0, alu.a} + {1'b0, alu.b} + {16'h0000, cin};
      nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, cin};
    end
    unique case (alu.op)
      CSF_OP_AND: res = alu.a & alu.b;
      CSF_OP_OR: res = alu.a | alu.b;
      CSF_OP_XOR: res = alu.a ^ alu.b;
      CSF_OP_PASS: res = alu.a;
      default: res = sum[15:0];
    endcase
    if (alu.byte_mode) begin
      res = {8'h00, res[7:0]};
    end
    msb = alu.byte_mode ? res[7] : res[15];
    zero = alu.byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
    // Logical ops leave carry and overflow cleared
    cout = 1'b0;
    ovf = 1'b0;
    hc = 1'b0;
    if (alu.op <= CSF_OP_SBB) begin
      cout = alu.byte_mode ? (alu.a[8] ^ alu.b[8] ^ sum[8]) : sum[16];
      hc = nib[4];
      if (alu.byte_mode) begin
        ovf = sub_op ? ((alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ res[7]))
                     : (~(alu.a[7] ^ alu.b[7]) & (alu.a[7] ^ res[7]));
      end else begin
        ovf = sub_op ? ((alu.a[15] ^ alu.b[15]) & (alu.a[15] ^ res[15]))
                     : (~(alu.a[15] ^ alu.b[15]) & (alu.a[15] ^ res[15]));
      end
    end
  end

  // ----------------------------------------------------------------
  // Address operands
  // ----------------------------------------------------------------
  // Fixed slots: 3 base word, 5 frame base, 6 source, 7 destination.
  // Taps the stored words so an address never waits a read cycle.
  assign bx_v = gen_regs[3];
  assign bp_v = gen_regs[5];
  assign si_v = gen_regs[6];
  assign di_v = gen_regs[7];

  always_comb begin
    unique case (base_sel)
      2'h1: base_v = bx_v;
      2'h2: base_v = bp_v;
      default: base_v = 16'h0000;
    endcase
    unique case (index_sel)
      2'h1: index_v = si_v;
      2'h2: index_v = di_v;
      default: index_v = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.step_irq = 1'b0;
    st_d.take_int = 1'b0;
    // Carry out of the 16-bit sum is dropped
    st_d.eff = base_v + index_v + disp;
    if (alu.en) begin
      st_d.res = res;
      st_d.flags[CSF_BIT_CARRY] = cout;
      st_d.flags[CSF_BIT_PARITY] = ~(^res[7:0]);
      st_d.flags[CSF_BIT_HALF] = hc;
      st_d.flags[CSF_BIT_ZERO] = zero;
      st_d.flags[CSF_BIT_SIGN] = msb;
      st_d.flags[CSF_BIT_OVFL] = ovf;
    end
    if (flags_load) begin
      st_d.flags = (flags_data & (CSF_RESULT_MASK | CSF_CTRL_MASK));
    end
    st_d.flags = st_d.flags & (CSF_RESULT_MASK | CSF_CTRL_MASK);
    if (seg_wr_en) begin
      st_d.seg[seg_idx] = seg_data;
    end
    if (ip_load) begin
      st_d.ip = ip_data;
    end else if (instr_done) begin
      st_d.ip = st_q.ip + {12'h000, instr_len};
    end
    // trap after next instruction, then clear
    if (instr_done && st_q.trap_armed) begin
      st_d.step_irq = 1'b1;
      st_d.flags[CSF_BIT_TRAP] = 1'b0;
      st_d.trap_armed = 1'b0;
    end else begin
      st_d.trap_armed = st_q.flags[CSF_BIT_TRAP];
    end
    st_d.take_int = maskable_req && instr_done
                    && st_q.flags[CSF_BIT_INTEN];
    if (string_step) begin
      st_d.delta = st_q.flags[CSF_BIT_DIR] ? 16'hFFFF : 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign flags_q = st_q.flags;
  assign seg_q = st_q.seg;
  assign ip_q = st_q.ip;
  assign alu_result_q = st_q.res;
  assign eff_offset_q = st_q.eff;
  assign take_maskable_q = st_q.take_int;
  assign single_step_irq_q = st_q.step_irq;
  assign string_delta_q = st_q.delta;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_trap_step;
    instr_done && st_q.trap_armed;
  endsequence

  chk_zero_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    alu.en && !flags_load |=> flags_q[CSF_BIT_ZERO] == (alu_result_q == 0))
    else $error("zero flag disagrees with result");
  chk_parity_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    alu.en && !flags_load |=>
      flags_q[CSF_BIT_PARITY] == ~(^alu_result_q[7:0]))
    else $error("parity flag wrong");
  chk_sign_flag: assert property (
    @(posedge core_clk) disable iff (reset)
    alu.en && !alu.byte_mode && !flags_load |=>
      flags_q[CSF_BIT_SIGN] == alu_result_q[15])
    else $error("sign flag wrong");
  chk_carry_add: assert property (
    @(posedge core_clk) disable iff (reset)
    alu.en && alu.op == CSF_OP_ADD && !alu.byte_mode && !flags_load
      |=> flags_q[CSF_BIT_CARRY] == (alu_result_q < $past(alu.a)))
    else $error("carry flag wrong");
  chk_trap_pulse: assert property (
    @(posedge core_clk) disable iff (reset)
    s_trap_step |=> single_step_irq_q && !flags_q[CSF_BIT_TRAP])
    else $error("single step trap not raised or not cleared");
  chk_int_gate: assert property (
    @(posedge core_clk) disable iff (reset)
    take_maskable_q |-> $past(flags_q[CSF_BIT_INTEN]))
    else $error("maskable interrupt taken while disabled");
  chk_dir_step: assert property (
    @(posedge core_clk) disable iff (reset)
    string_step |=> string_delta_q ==
      ($past(flags_q[CSF_BIT_DIR]) ? 16'hFFFF : 16'h0001))
    else $error("string step direction wrong");
  chk_reserved_bits: assert property (
    @(posedge core_clk) disable iff (reset)
    (flags_q & ~(CSF_RESULT_MASK | CSF_CTRL_MASK)) == 16'h0000)
    else $error("reserved flag bit set");
  chk_ip_advance: assert property (
    @(posedge core_clk) disable iff (reset)
    instr_done && !ip_load |=> ip_q == $past(ip_q) + $past(instr_len))
    else $error("instruction pointer did not advance");
endmodule // csf_core
`default_nettype wire

// file: bench/csf_core_tb.sv
// Self-checking bench for the status flag and register set core.
// Assumes csf_pkg is compiled first; the bench drives every core input.
`default_nettype none
module csf_core_tb
  import csf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic core_clk = 1'b0;
  logic clk_run = 1'b1;
  logic reset = 1'b1;
  csf_alu_s alu = '0;
  csf_wr_s gen_wr = '0;
  logic [2:0] rd_a_idx = 3'h0;
  logic [2:0] rd_b_idx = 3'h3;
  logic [1:0] base_sel = 2'h1;
  logic [1:0] index_sel = 2'h1;
  logic [15:0] disp = 16'h0003;
  logic seg_wr_en = 1'b0;
  logic [1:0] seg_idx = 2'h2;
  logic [15:0] seg_data = 16'hBEEF;
  logic instr_done = 1'b0;
  logic [3:0] instr_len = 4'h3;
  logic ip_load = 1'b0;
  logic [15:0] ip_data = 16'h1000;
  logic flags_load = 1'b0;
  logic [15:0] flags_data = 16'h0000;
  logic maskable_req = 1'b0;
  logic string_step = 1'b0;
  logic [15:0] rd_a_q, rd_b_q, eff_offset_q, ip_q, flags_q;
  logic [15:0] alu_result_q, string_delta_q;
  logic [3:0][15:0] seg_q;
  logic take_maskable_q, single_step_irq_q;
  int fail_count = 0;
  int comparisons = 0;

  // Stopping the clock through clk_run exercises static state retention
  initial begin
    forever begin
      #5;
      if (clk_run) core_clk = ~core_clk;
    end
  end

  csf_core u_csf_core (.core_clk(core_clk), .reset(reset), .alu(alu),
    .gen_wr(gen_wr), .rd_a_idx(rd_a_idx), .rd_b_idx(rd_b_idx),
    .rd_a_q(rd_a_q), .rd_b_q(rd_b_q), .base_sel(base_sel),
    .index_sel(index_sel), .disp(disp), .eff_offset_q(eff_offset_q),
    .seg_wr_en(seg_wr_en), .seg_idx(seg_idx), .seg_data(seg_data),
    .seg_q(seg_q), .instr_done(instr_done), .instr_len(instr_len),
    .ip_load(ip_load), .ip_data(ip_data), .ip_q(ip_q),
    .flags_load(flags_load), .flags_data(flags_data),
    .maskable_req(maskable_req), .string_step(string_step),
    .flags_q(flags_q), .alu_result_q(alu_result_q),
    .take_maskable_q(take_maskable_q),
    .single_step_irq_q(single_step_irq_q),
    .string_delta_q(string_delta_q));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic alu_op(input csf_op_e op, input logic bm,
                        input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk);
    alu <= '{1'b1, op, bm, a, b};
    @(posedge core_clk);
    alu.en <= 1'b0;
    #1;
  endtask

  task automatic load_flags(input logic [15:0] v);
    @(posedge core_clk);
    flags_load <= 1'b1;
    flags_data <= v;
    @(posedge core_clk);
    flags_load <= 1'b0;
    #1;
  endtask

  task automatic done_pulse(input logic mreq);
    @(posedge core_clk);
    instr_done <= 1'b1;
    maskable_req <= mreq;
    @(posedge core_clk);
    instr_done <= 1'b0;
    maskable_req <= 1'b0;
    #1;
  endtask

  task automatic str_step;
    @(posedge core_clk);
    string_step <= 1'b1;
    @(posedge core_clk);
    string_step <= 1'b0;
    #1;
  endtask

  task automatic wr_reg(input logic [2:0] idx, input logic [1:0] ln,
                        input logic [15:0] d);
    @(posedge core_clk);
    gen_wr <= '{1'b1, idx, ln, d};
    @(posedge core_clk);
    gen_wr.en <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_arith;
    alu_op(CSF_OP_ADD, 1'b0, 16'hFFFF, 16'h0001);
    chk(alu_result_q, 16'h0000, "add wrap");
    chk(flags_q, 16'h0055, "add flags");
    alu_op(CSF_OP_ADC, 1'b0, 16'h0000, 16'h0000);
    chk(alu_result_q, 16'h0001, "carry in");
    chk(flags_q, 16'h0000, "odd parity");
    alu_op(CSF_OP_ADD, 1'b1, 16'h127F, 16'h0001);
    chk(alu_result_q, 16'h0080, "byte add");
    chk(flags_q, 16'h0890, "byte overflow");
    alu_op(CSF_OP_SUB, 1'b0, 16'h0000, 16'h0001);
    chk(flags_q, 16'h0095, "borrow flags");
    alu_op(CSF_OP_AND, 1'b0, 16'hFFFF, 16'h00F0);
    chk(flags_q, 16'h0004, "logic flags");
    alu_op(CSF_OP_SUB, 1'b1, 16'h0010, 16'h0011);
    chk(alu_result_q, 16'h00FF, "byte sub");
    chk(flags_q, 16'h0095, "byte borrow");
    alu_op(CSF_OP_SBB, 1'b0, 16'h8000, 16'h0000);
    chk(alu_result_q, 16'h7FFF, "borrow in");
    chk(flags_q, 16'h0814, "sub overflow");
    alu_op(CSF_OP_XOR, 1'b0, 16'hA5A5, 16'h5A5A);
    chk(alu_result_q, 16'hFFFF, "xor");
    chk(flags_q, 16'h0084, "xor flags");
    alu_op(CSF_OP_OR, 1'b0, 16'h0000, 16'h0000);
    chk(flags_q, 16'h0044, "or zero");
    alu_op(CSF_OP_PASS, 1'b0, 16'h0300, 16'hFFFF);
    chk(alu_result_q, 16'h0300, "pass");
    chk(flags_q, 16'h0004, "pass flags");
    $display("test arith done");
  endtask

  task automatic t_ctrl;
    load_flags(16'hF6FF);
    chk(flags_q, 16'h06D5, "load masks spare bits");
    alu_op(CSF_OP_ADD, 1'b0, 16'h0001, 16'h0001);
    chk(flags_q, 16'h0600, "control bits kept");
    str_step();
    chk(string_delta_q, 16'hFFFF, "step down");
    load_flags(16'h0000);
    str_step();
    chk(string_delta_q, 16'h0001, "step up");
    $display("test control done");
  endtask

  task automatic t_int;
    load_flags(16'h0200);
    done_pulse(1'b1);
    chk({15'h0000, take_maskable_q}, 16'h0001, "enabled take");
    load_flags(16'h0000);
    done_pulse(1'b1);
    chk({15'h0000, take_maskable_q}, 16'h0000, "masked");
    $display("test interrupt done");
  endtask

  task automatic t_trap;
    @(posedge core_clk);
    ip_load <= 1'b1;
    flags_load <= 1'b1;
    flags_data <= 16'h0100;
    @(posedge core_clk);
    ip_load <= 1'b0;
    flags_load <= 1'b0;
    #1;
    chk(flags_q, 16'h0100, "trap set");
    done_pulse(1'b0);
    chk({15'h0000, single_step_irq_q}, 16'h0001, "trap fires");
    chk(flags_q, 16'h0000, "trap clears");
    chk(ip_q, 16'h1003, "ip advance");
    $display("test trap done");
  endtask

  task automatic t_regs;
    wr_reg(3'h0, 2'h3, 16'h1234);
    wr_reg(3'h0, 2'h1, 16'h00AB);
    wr_reg(3'h0, 2'h2, 16'hCD00);
    wr_reg(3'h3, 2'h3, 16'h0100);
    wr_reg(3'h6, 2'h3, 16'h0020);
    seg_wr_en <= 1'b1;
    @(posedge core_clk);
    seg_wr_en <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(rd_a_q, 16'hCDAB, "byte lanes");
    chk(rd_b_q, 16'h0100, "full word");
    chk(eff_offset_q, 16'h0123, "offset sum");
    chk(seg_q[2], 16'hBEEF, "segment");
    $display("test registers done");
  endtask

  task automatic t_static;
    clk_run = 1'b0;
    #1000;
    clk_run = 1'b1;
    @(posedge core_clk);
    #1;
    chk(seg_q[2], 16'hBEEF, "segment kept");
    chk(ip_q, 16'h1003, "ip kept");
    chk(rd_a_q, 16'hCDAB, "register kept");
    $display("test static done");
  endtask

  task automatic t_addr;
    wr_reg(3'h5, 2'h1, 16'h0200);
    wr_reg(3'h7, 2'h3, 16'h0040);
    base_sel <= 2'h2;
    index_sel <= 2'h2;
    disp <= 16'hFFF0;
    @(posedge core_clk);
    #1;
    chk(eff_offset_q, 16'h0230, "frame plus dest wraps");
    @(posedge core_clk);
    base_sel <= 2'h0;
    index_sel <= 2'h0;
    @(posedge core_clk);
    #1;
    chk(eff_offset_q, 16'hFFF0, "displacement only");
    $display("test address done");
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Whole run is under two microseconds; this bound only catches a hang
  initial begin
    #20000;
    fail_count++;
    conclude();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(flags_q, CSF_FLAGS_RESET, "reset flags");
    chk(ip_q, CSF_REG_RESET, "reset ip");
    t_arith();
    t_ctrl();
    t_int();
    t_trap();
    t_regs();
    t_static();
    t_addr();
    conclude();
  end
endmodule // csf_core_tb
`default_nettype wire
